// ===== hdd_engine.sv
// Descriptor list DMA engine: per channel and direction list walking and buffer moves
//
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module hdd_engine (
  input  wire logic                         clk_i,
  input  wire logic                         rst_n_i,
  input  wire logic [7:0]                   addr_i,
  input  wire logic [31:0]                  wr_data_i,
  input  wire logic                         wr_i,
  input  wire logic                         rd_i,
  output logic      [31:0]                  rd_data_o,
  output logic                              mem_req_o,
  output hdd_pkg::hdd_mem_req_t             mem_o,
  input  wire logic                         mem_ack_i,
  input  wire logic [31:0]                  mem_rdata_i,
  output logic                              tx_valid_o,
  output hdd_pkg::hdd_tx_beat_t             tx_beat_o,
  input  wire logic                         tx_ready_i,
  output logic                              rx_req_o,
  output logic      [hdd_pkg::CH_W-1:0]     rx_ch_o,
  input  wire logic                         rx_valid_i,
  input  wire hdd_pkg::hdd_rx_beat_t        rx_beat_i,
  input  wire logic                         rx_sof_i,
  input  wire logic [hdd_pkg::CH_W-1:0]     rx_sof_ch_i,
  output logic                              eob_event_o,
  output logic      [hdd_pkg::SLOT_W-1:0]   eob_slot_o,
  output logic                              nobuf_event_o,
  output logic      [hdd_pkg::CH_W-1:0]     nobuf_ch_o
);

  hdd_pkg::hdd_state_s_t r_reg;
  hdd_pkg::hdd_state_s_t r_next;

  function automatic logic [2:0] clip4(input logic [hdd_pkg::BUFFER_LENGTH_W-1:0] rem);
    clip4 = (rem >= hdd_pkg::BUFFER_LENGTH_W'(4)) ? 3'h4 : rem[2:0];
  endfunction

  function automatic logic [3:0] lane_mask(input logic [2:0] nb);
    case (nb)
      3'h0:    lane_mask = 4'h0;
      3'h1:    lane_mask = 4'h1;
      3'h2:    lane_mask = 4'h3;
      3'h3:    lane_mask = 4'h7;
      default: lane_mask = 4'hf;
    endcase
  endfunction

  // Owner sense is per direction
  function automatic logic dev_owned(input logic is_rx, input logic [31:0] w);
    dev_owned = is_rx ? (w[hdd_pkg::OWNER_BIT] == hdd_pkg::RX_DEV_OWNER)
                      : (w[hdd_pkg::OWNER_BIT] == hdd_pkg::TX_DEV_OWNER);
  endfunction

  logic                          is_rx;
  logic [hdd_pkg::SLOT_W-1:0]    s;
  logic [hdd_pkg::BUFFER_LENGTH_W-1:0]    buffer_length;
  logic [hdd_pkg::BUFFER_LENGTH_W-1:0]    rem;
  logic [2:0]                    nb;
  logic [hdd_pkg::BUFFER_LENGTH_W-1:0]    nrem;
  logic [2:0]                    take;
  logic                          finish;
  logic                          go_cptr;
  logic                          found;
  logic [hdd_pkg::SLOT_W-1:0]    pick;
  logic [hdd_pkg::SLOT_W-1:0]    idx;
  logic [hdd_pkg::SLOT_W-1:0]    ridx;
  logic [hdd_pkg::SLOT_W-1:0]    sof_slot;
  logic [31:0]                   base;
  logic [31:0]                   stat;
  logic                          end_of_buffer_irq_enable;

  always_comb begin
    r_next   = r_reg;
    s        = r_reg.slot;
    is_rx    = r_reg.slot[0];
    buffer_length     = r_reg.desc[hdd_pkg::BUFFER_LENGTH_W-1:0];
    rem      = buffer_length - r_reg.boff;
    nb       = clip4(rem);
    nrem     = rem - hdd_pkg::BUFFER_LENGTH_W'(nb);
    take     = (hdd_pkg::BUFFER_LENGTH_W'(rx_beat_i.bytes) > rem) ? rem[2:0] : rx_beat_i.bytes;
    finish   = 1'b0;
    go_cptr  = 1'b0;
    found    = 1'b0;
    pick     = '0;
    idx      = '0;
    ridx     = addr_i[hdd_pkg::SLOT_W+1:2];
    sof_slot = {rx_sof_ch_i, 1'b1};
    base     = '0;
    end_of_buffer_irq_enable     = is_rx ? r_reg.desc[hdd_pkg::RX_END_OF_BUFFER_IRQ_ENABLE_BIT]
                     : r_reg.desc[hdd_pkg::TX_END_OF_BUFFER_IRQ_ENABLE_BIT];
    stat     = 32'h0000_0000;
    stat[hdd_pkg::BUFFER_LENGTH_W-1:0] = r_reg.boff;
    if (is_rx) begin
      stat[hdd_pkg::OWNER_BIT]   = ~hdd_pkg::RX_DEV_OWNER;
      stat[hdd_pkg::RX_STAT_EOM] = r_reg.eom_seen;
    end else begin
      stat[hdd_pkg::OWNER_BIT]   = ~hdd_pkg::TX_DEV_OWNER;
      stat[hdd_pkg::TX_EOM_BIT]  = r_reg.desc[hdd_pkg::TX_EOM_BIT];
    end

    r_next.eob_evt   = 1'b0;
    r_next.nobuf_evt = 1'b0;
    r_next.rdata     = 32'h0000_0000;

    // Poll divider releases every slot that waits on a polled descriptor
    if (r_reg.poll_cnt == hdd_pkg::POLL_W'(hdd_pkg::POLL_CYC - 1)) begin
      r_next.poll_cnt  = '0;
      r_next.ready     = r_reg.ready | r_reg.wait_poll;
      r_next.wait_poll = '0;
    end else begin
      r_next.poll_cnt = r_reg.poll_cnt + hdd_pkg::POLL_W'(1);
    end

    // Opening flag seen on a receiver holding no device-owned buffer
    if (rx_sof_i && !r_reg.rx_owned[sof_slot]) begin
      r_next.nobuf_evt = 1'b1;
      r_next.nobuf_ch  = rx_sof_ch_i;
    end

    unique case (r_reg.st)
      hdd_pkg::ST_SCHED: begin
        // Round robin over slots, each slot walks its own list
        for (int i = 1; i <= hdd_pkg::SLOT_NUM; i++) begin
          idx = hdd_pkg::SLOT_W'(int'(r_reg.rr) + i);
          if (!found && r_reg.ready[idx]) begin
            found = 1'b1;
            pick  = idx;
          end
        end
        if (r_reg.en && found) begin
          r_next.slot        = pick;
          r_next.rr          = pick;
          r_next.ready[pick] = 1'b0;
          base               = r_reg.cur[pick];
          if (r_reg.jump[pick]) begin
            base               = r_reg.head[pick];
            r_next.cur[pick]   = r_reg.head[pick];
            r_next.jump[pick]  = 1'b0;
          end
          r_next.mem_req  = 1'b1;
          r_next.mem.we   = 1'b0;
          r_next.mem.be   = 4'hf;
          r_next.mem.addr = (base & hdd_pkg::ALIGN_MASK) + hdd_pkg::DESC_CTRL_OFS;
          r_next.st       = hdd_pkg::ST_RD_CTRL;
        end
      end
      hdd_pkg::ST_RD_CTRL: begin
        if (mem_ack_i) begin
          r_next.desc = mem_rdata_i;
          if (dev_owned(is_rx, mem_rdata_i)) begin
            r_next.rx_owned[s] = is_rx;
            r_next.mem.addr    = r_reg.cur[s] + hdd_pkg::DESC_DPTR_OFS;
            r_next.st          = hdd_pkg::ST_RD_DPTR;
          end else begin
            // Host owns it: poll again later, or wait for activate
            r_next.mem_req = 1'b0;
            if (!mem_rdata_i[hdd_pkg::NOPOLL_BIT]) begin
              r_next.wait_poll[s] = 1'b1;
            end
            r_next.st = hdd_pkg::ST_SCHED;
          end
        end
      end
      hdd_pkg::ST_RD_DPTR: begin
        if (mem_ack_i) begin
          r_next.dptr     = mem_rdata_i;
          r_next.mem.addr = r_reg.cur[s] + hdd_pkg::DESC_NEXT_OFS;
          r_next.st       = hdd_pkg::ST_RD_NEXT;
        end
      end
      hdd_pkg::ST_RD_NEXT: begin
        if (mem_ack_i) begin
          r_next.nptr     = mem_rdata_i & hdd_pkg::ALIGN_MASK;
          r_next.boff     = '0;
          r_next.eom_seen = 1'b0;
          r_next.mem_req  = 1'b0;
          if (buffer_length == '0) begin
            finish = 1'b1;
          end else if (!is_rx) begin
            r_next.mem_req  = 1'b1;
            r_next.mem.addr = r_reg.dptr;
            r_next.mem.be   = lane_mask(nb);
            r_next.st       = hdd_pkg::ST_TX_RD;
          end else begin
            r_next.rx_req = 1'b1;
            r_next.st     = hdd_pkg::ST_RX_WAIT;
          end
        end
      end
      hdd_pkg::ST_TX_RD: begin
        if (mem_ack_i) begin
          r_next.mem_req  = 1'b0;
          r_next.tx_valid = 1'b1;
          r_next.tx.data  = mem_rdata_i;
          r_next.tx.bytes = nb;
          r_next.tx.ch    = s[hdd_pkg::SLOT_W-1:1];
          r_next.tx.last  = (nrem == '0) && r_reg.desc[hdd_pkg::TX_EOM_BIT];
          r_next.tx.idle_code_select = '0;
          r_next.tx.pad_fill_enable  = 1'b0;
          r_next.tx.pad_fill_count   = '0;
          r_next.tx.repeat_msg       = 1'b0;
          if ((nrem == '0) && r_reg.desc[hdd_pkg::TX_EOM_BIT]) begin
            r_next.tx.idle_code_select = r_reg.desc[hdd_pkg::TX_IC_LSB +: 2];
            r_next.tx.pad_fill_enable  = r_reg.desc[hdd_pkg::TX_PAD_FILL_ENABLE_BIT];
            r_next.tx.pad_fill_count   = r_reg.desc[hdd_pkg::TX_PAD_FILL_COUNT_LSB +: 8];
            r_next.tx.repeat_msg       = r_reg.desc[hdd_pkg::TX_REPEAT_BIT];
          end
          r_next.st = hdd_pkg::ST_TX_PUSH;
        end
      end
      hdd_pkg::ST_TX_PUSH: begin
        if (tx_ready_i) begin
          r_next.tx_valid = 1'b0;
          r_next.boff     = r_reg.boff + hdd_pkg::BUFFER_LENGTH_W'(nb);
          if (nrem == '0) begin
            finish = 1'b1;
          end else begin
            r_next.mem_req  = 1'b1;
            r_next.mem.addr = r_reg.dptr + 32'(r_next.boff);
            r_next.mem.be   = lane_mask(clip4(nrem));
            r_next.st       = hdd_pkg::ST_TX_RD;
          end
        end
      end
      hdd_pkg::ST_RX_WAIT: begin
        if (rx_valid_i) begin
          r_next.rx_req    = 1'b0;
          r_next.mem_req   = 1'b1;
          r_next.mem.we    = 1'b1;
          r_next.mem.addr  = r_reg.dptr + 32'(r_reg.boff);
          r_next.mem.wdata = rx_beat_i.data;
          r_next.mem.be    = lane_mask(take);
          r_next.boff      = r_reg.boff + hdd_pkg::BUFFER_LENGTH_W'(take);
          r_next.eom_seen  = rx_beat_i.end_of_message_flag;
          r_next.st        = hdd_pkg::ST_RX_WR;
        end
      end
      hdd_pkg::ST_RX_WR: begin
        if (mem_ack_i) begin
          r_next.mem_req = 1'b0;
          if (r_reg.eom_seen || (r_reg.boff == buffer_length)) begin
            finish = 1'b1;
          end else begin
            r_next.rx_req = 1'b1;
            r_next.st     = hdd_pkg::ST_RX_WAIT;
          end
        end
      end
      hdd_pkg::ST_WR_STAT: begin
        if (mem_ack_i) begin
          go_cptr = 1'b1;
        end
      end
      hdd_pkg::ST_WR_CPTR: begin
        if (mem_ack_i) begin
          r_next.mem_req  = 1'b0;
          r_next.ready[s] = 1'b1;
          r_next.st       = hdd_pkg::ST_SCHED;
        end
      end
    endcase

    if (finish) begin
      r_next.eob_evt     = end_of_buffer_irq_enable;
      r_next.eob_slot    = s;
      r_next.rx_owned[s] = 1'b0;
      r_next.cur[s]      = r_reg.nptr;
      stat[hdd_pkg::BUFFER_LENGTH_W-1:0] = r_next.boff;
      r_next.mem_req     = 1'b1;
      r_next.mem.we      = 1'b1;
      r_next.mem.be      = 4'hf;
      r_next.mem.addr    = r_reg.cur[s] + hdd_pkg::DESC_CTRL_OFS;
      r_next.mem.wdata   = stat;
      r_next.st          = hdd_pkg::ST_WR_STAT;
      go_cptr            = r_reg.inh;
    end
    // Current pointer kept in shared memory, one word per slot
    if (go_cptr) begin
      r_next.mem_req   = 1'b1;
      r_next.mem.we    = 1'b1;
      r_next.mem.be    = 4'hf;
      r_next.mem.addr  = r_reg.gbase + 32'({s, 2'b00});
      r_next.mem.wdata = r_next.cur[s];
      r_next.st        = hdd_pkg::ST_WR_CPTR;
    end

    // Register writes last, so host requests win
    if (wr_i) begin
      if (addr_i == hdd_pkg::REG_CTRL) begin
        r_next.en  = wr_data_i[hdd_pkg::CTRL_EN_BIT];
        r_next.inh = wr_data_i[hdd_pkg::CTRL_INH_BIT];
      end else if (addr_i == hdd_pkg::REG_GBASE) begin
        r_next.gbase = wr_data_i & hdd_pkg::ALIGN_MASK;
      end else if (addr_i == hdd_pkg::REG_ACTIVATE) begin
        r_next.ready = r_next.ready | wr_data_i[hdd_pkg::SLOT_NUM-1:0];
      end else if (addr_i[7:6] == hdd_pkg::REG_HEAD_PAGE) begin
        r_next.head[ridx] = wr_data_i & hdd_pkg::ALIGN_MASK;
        r_next.jump[ridx] = 1'b1;
      end
    end
    if (rd_i) begin
      if (addr_i == hdd_pkg::REG_CTRL) begin
        r_next.rdata[hdd_pkg::CTRL_EN_BIT]  = r_reg.en;
        r_next.rdata[hdd_pkg::CTRL_INH_BIT] = r_reg.inh;
      end else if (addr_i == hdd_pkg::REG_GBASE) begin
        r_next.rdata = r_reg.gbase;
      end else if (addr_i == hdd_pkg::REG_STATUS) begin
        r_next.rdata = 32'(r_reg.ready);
      end else if (addr_i[7:6] == hdd_pkg::REG_HEAD_PAGE) begin
        r_next.rdata = r_reg.head[ridx];
      end else if (addr_i[7:6] == hdd_pkg::REG_CUR_PAGE) begin
        r_next.rdata = r_reg.cur[ridx];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r_reg       <= '0;
      r_reg.st    <= hdd_pkg::ST_SCHED;
      r_reg.en    <= hdd_pkg::CTRL_EN_RST;
      r_reg.inh   <= hdd_pkg::CTRL_INH_RST;
      r_reg.gbase <= hdd_pkg::GBASE_RST;
      r_reg.cur   <= {hdd_pkg::SLOT_NUM{hdd_pkg::PTR_RST}};
      r_reg.head  <= {hdd_pkg::SLOT_NUM{hdd_pkg::PTR_RST}};
    end else begin
      r_reg <= r_next;
    end
  end

  assign rd_data_o     = r_reg.rdata;
  assign mem_req_o     = r_reg.mem_req;
  assign mem_o         = r_reg.mem;
  assign tx_valid_o    = r_reg.tx_valid;
  assign tx_beat_o     = r_reg.tx;
  assign rx_req_o      = r_reg.rx_req;
  assign rx_ch_o       = r_reg.slot[hdd_pkg::SLOT_W-1:1];
  assign eob_event_o   = r_reg.eob_evt;
  assign eob_slot_o    = r_reg.eob_slot;
  assign nobuf_event_o = r_reg.nobuf_evt;
  assign nobuf_ch_o    = r_reg.nobuf_ch;
endmodule
`default_nettype wire

// ===== hdd_host_mem.sv
// Behavioural host shared memory answering the engine's memory requests
`timescale 1ns/1ps
`default_nettype none
module hdd_host_mem (
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  mem_req_i,
  input  wire hdd_pkg::hdd_mem_req_t mem_i,
  input  wire logic [1:0]            slow_i,
  output logic                       mem_ack_o,
  output logic [31:0]                mem_rdata_o
);
  logic [31:0] mem [int unsigned];
  logic [31:0] guard_addr;
  int          guard_hits;
  int          wait_cnt;
  initial guard_hits = 0;
  initial guard_addr = 32'hffff_fff0;
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_ack_o   <= 1'b0;
      mem_rdata_o <= 32'h5a5a_a5a5;
      wait_cnt    = 0;
    end else if (mem_ack_o) begin
      mem_ack_o   <= 1'b0;
      mem_rdata_o <= ~mem_rdata_o;
    end else if (mem_req_i) begin
      if (wait_cnt < int'(slow_i)) begin
        wait_cnt++;
      end else begin
        wait_cnt  = 0;
        mem_ack_o <= 1'b1;
        if (mem_i.addr == guard_addr) guard_hits++;
        if (!mem.exists(mem_i.addr)) mem[mem_i.addr] = ~mem_i.addr;
        if (mem_i.we) begin
          for (int b = 0; b < 4; b++) begin
            if (mem_i.be[b]) mem[mem_i.addr][8*b+:8] = mem_i.wdata[8*b+:8];
          end
        end else begin
          mem_rdata_o <= mem[mem_i.addr];
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== hdd_monitor.sv
// Port checker for the descriptor list DMA engine
`timescale 1ns/1ps
`default_nettype none
module hdd_monitor (
  input wire logic                  clk_i,
  input wire logic                  rst_n_i,
  input wire logic [7:0]            addr_i,
  input wire logic [31:0]           wr_data_i,
  input wire logic                  wr_i,
  input wire logic                  rd_i,
  input wire logic [31:0]           rd_data_o,
  input wire logic                  mem_req_o,
  input wire hdd_pkg::hdd_mem_req_t mem_o,
  input wire logic                  mem_ack_i,
  input wire logic                  tx_valid_o,
  input wire hdd_pkg::hdd_tx_beat_t tx_beat_o,
  input wire logic                  tx_ready_i,
  input wire logic                  rx_req_o,
  input wire logic                  rx_sof_i,
  input wire logic                  nobuf_event_o
);
  logic       en_seen_reg;
  logic [1:0] ctrl_reg;
  logic [7:0] sof_age_reg;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      en_seen_reg <= 1'b0;
      ctrl_reg    <= 2'b00;
      sof_age_reg <= 8'hff;
    end else begin
      if (wr_i && addr_i == hdd_pkg::REG_CTRL) begin
        ctrl_reg    <= wr_data_i[1:0];
        en_seen_reg <= en_seen_reg | wr_data_i[0];
      end
      if (rx_sof_i) sof_age_reg <= 8'h00;
      else if (sof_age_reg != 8'hff) sof_age_reg <= sof_age_reg + 8'h01;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_mem_wait;
    mem_req_o && !mem_ack_i;
  endsequence
  sequence s_mem_hold;
    mem_req_o && $stable(mem_o);
  endsequence
  chk_mem_req_hold: assert property (s_mem_wait |=> s_mem_hold)
    else $error("memory request changed before acknowledge");
  chk_mem_word_aligned: assert property (mem_req_o |-> mem_o.addr[1:0] == 2'b00)
    else $error("memory address not word aligned");
  chk_quiet_disabled: assert property (!en_seen_reg |-> !mem_req_o && !tx_valid_o && !rx_req_o)
    else $error("activity before the engine was enabled");
  chk_ctrl_readback: assert property (rd_i && addr_i == hdd_pkg::REG_CTRL |=> rd_data_o[1:0] == ctrl_reg)
    else $error("control readback differs from written value");
  chk_tx_beat_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_beat_o))
    else $error("transmit beat changed while stalled");
  chk_tx_byte_count: assert property (tx_valid_o |-> tx_beat_o.bytes inside {[3'd1:3'd4]})
    else $error("transmit beat byte count out of range");
  chk_pad_only_eom: assert property (tx_valid_o && !tx_beat_o.last |-> !tx_beat_o.pad_fill_enable && !tx_beat_o.repeat_msg)
    else $error("pad or repeat set on a beat without end of message");
  chk_nobuf_cause: assert property (nobuf_event_o |-> sof_age_reg <= 8'd16)
    else $error("no-buffer event without a recent opening flag");
endmodule
`default_nettype wire

// ===== hdd_pkg.sv
// Constants, types and state layout for the descriptor list DMA engine
`default_nettype none
package hdd_pkg;
  // Channel and slot geometry; slot index is {channel, direction}, direction 1 is receive
  localparam int CH_NUM   = 4;
  localparam int CH_W     = 2;
  localparam int SLOT_NUM = 2 * CH_NUM;
  localparam int SLOT_W   = 3;
  localparam int BUFFER_LENGTH_W   = 14;

  // Register port byte addresses
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_GBASE     = 8'h04;
  localparam logic [7:0] REG_ACTIVATE  = 8'h08;
  localparam logic [7:0] REG_STATUS    = 8'h0c;
  localparam logic [1:0] REG_HEAD_PAGE = 2'h1;
  localparam logic [1:0] REG_CUR_PAGE  = 2'h2;

  // Control register fields and reset values
  localparam int          CTRL_EN_BIT  = 0;
  localparam int          CTRL_INH_BIT = 1;
  localparam logic        CTRL_EN_RST  = 1'b0;
  localparam logic        CTRL_INH_RST = 1'b0;
  localparam logic [31:0] GBASE_RST    = 32'h0000_0000;
  localparam logic [31:0] PTR_RST      = 32'h0000_0000;

  // Descriptor word byte offsets
  localparam logic [31:0] DESC_CTRL_OFS = 32'h0000_0000;
  localparam logic [31:0] DESC_DPTR_OFS = 32'h0000_0004;
  localparam logic [31:0] DESC_NEXT_OFS = 32'h0000_0008;
  localparam logic [31:0] ALIGN_MASK    = 32'hffff_fffc;

  // Buffer control word fields, common part
  localparam int OWNER_BIT  = 31;
  localparam int NOPOLL_BIT = 30;
  // Transmit layout
  localparam int TX_EOM_BIT     = 29;
  localparam int TX_END_OF_BUFFER_IRQ_ENABLE_BIT    = 28;
  localparam int TX_IC_LSB      = 25;
  localparam int TX_PAD_FILL_ENABLE_BIT   = 24;
  localparam int TX_PAD_FILL_COUNT_LSB  = 16;
  localparam int TX_REPEAT_BIT  = 15;
  // Receive layout
  localparam int RX_END_OF_BUFFER_IRQ_ENABLE_BIT    = 29;
  localparam int RX_STAT_EOM    = 28;
  // Owner value that hands the buffer to the device, per direction
  localparam logic TX_DEV_OWNER = 1'b1;
  localparam logic RX_DEV_OWNER = 1'b0;

  // Poll interval for host-owned descriptors with polling enabled
  localparam int POLL_INTERVAL_NS = 1000;
  localparam int CLK_PERIOD_PS    = 5000;
  localparam int POLL_CYC         = (POLL_INTERVAL_NS * 1000) / CLK_PERIOD_PS;
  localparam int POLL_W           = 16;

  typedef enum logic [3:0] {
    ST_SCHED, ST_RD_CTRL, ST_RD_DPTR, ST_RD_NEXT, ST_TX_RD, ST_TX_PUSH,
    ST_RX_WAIT, ST_RX_WR, ST_WR_STAT, ST_WR_CPTR
  } hdd_state_t;

  typedef struct packed {
    logic        we;
    logic [31:0] addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } hdd_mem_req_t;

  typedef struct packed {
    logic [31:0]       data;
    logic [2:0]        bytes;
    logic [CH_W-1:0]   ch;
    logic              last;
    logic [1:0]        idle_code_select;
    logic              pad_fill_enable;
    logic [7:0]        pad_fill_count;
    logic              repeat_msg;
  } hdd_tx_beat_t;

  typedef struct packed {
    logic [31:0] data;
    logic [2:0]  bytes;
    logic        end_of_message_flag;
  } hdd_rx_beat_t;

  typedef struct packed {
    hdd_state_t                       st;
    logic [SLOT_W-1:0]                slot;
    logic [SLOT_W-1:0]                rr;
    logic [SLOT_NUM-1:0][31:0]        cur;
    logic [SLOT_NUM-1:0][31:0]        head;
    logic [SLOT_NUM-1:0]              jump;
    logic [SLOT_NUM-1:0]              ready;
    logic [SLOT_NUM-1:0]              wait_poll;
    logic [SLOT_NUM-1:0]              rx_owned;
    logic                             en;
    logic                             inh;
    logic [31:0]                      gbase;
    logic [31:0]                      rdata;
    logic                             mem_req;
    hdd_mem_req_t                     mem;
    logic [31:0]                      desc;
    logic [31:0]                      dptr;
    logic [31:0]                      nptr;
    logic [BUFFER_LENGTH_W-1:0]                boff;
    logic                             eom_seen;
    logic                             tx_valid;
    hdd_tx_beat_t                     tx;
    logic                             rx_req;
    logic                             eob_evt;
    logic [SLOT_W-1:0]                eob_slot;
    logic                             nobuf_evt;
    logic [CH_W-1:0]                  nobuf_ch;
    logic [POLL_W-1:0]                poll_cnt;
  } hdd_state_s_t;
endpackage
`default_nettype wire

// ===== testbench.sv
// Self-checking testbench for the descriptor list DMA engine
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic                  clk_i, rst_n_i, wr_i, rd_i, tx_ready_i, rx_sof_i;
  logic                  mem_req_o, mem_ack_i, tx_valid_o, rx_req_o;
  logic                  eob_event_o, nobuf_event_o;
  logic [1:0]            mem_slow, rx_sof_ch_i, rx_ch_o, nobuf_ch_o, nobuf_last;
  logic [2:0]            eob_slot_o;
  logic [7:0]            addr_i;
  logic [31:0]           wr_data_i, rd_data_o, mem_rdata_i, v, w0;
  hdd_pkg::hdd_mem_req_t mem_o;
  hdd_pkg::hdd_tx_beat_t tx_beat_o;
  int                    miscompares, num_checks, beats, nbytes, nobuf_hits;
  logic [31:0]           first_data;

  hdd_engine i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .mem_req_o(mem_req_o), .mem_o(mem_o),
    .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i), .tx_valid_o(tx_valid_o),
    .tx_beat_o(tx_beat_o), .tx_ready_i(tx_ready_i), .rx_req_o(rx_req_o), .rx_ch_o(rx_ch_o),
    .rx_valid_i(1'b0), .rx_beat_i('0), .rx_sof_i(rx_sof_i), .rx_sof_ch_i(rx_sof_ch_i),
    .eob_event_o(eob_event_o), .eob_slot_o(eob_slot_o), .nobuf_event_o(nobuf_event_o),
    .nobuf_ch_o(nobuf_ch_o));
  hdd_host_mem i_host (.clk_i(clk_i), .rst_n_i(rst_n_i), .mem_req_i(mem_req_o), .mem_i(mem_o),
    .slow_i(mem_slow), .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    tx_ready_i <= ($urandom_range(3) != 0);
    mem_slow   <= 2'($urandom_range(2));
    if (tx_valid_o && tx_ready_i) begin
      if (beats == 0 || beats == 2) first_data = tx_beat_o.data;
      beats++;
      nbytes += int'(tx_beat_o.bytes);
    end
    if (nobuf_event_o) begin
      nobuf_hits++;
      nobuf_last = nobuf_ch_o;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    addr_i <= a;
    wr_data_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(posedge clk_i);
    d = rd_data_o;
  endtask
  // Host builds a descriptor: control word, data pointer, next pointer
  task automatic put_desc(input logic [31:0] a, c, dp, nx);
    i_host.mem[a] = c;
    i_host.mem[a + 32'h4] = dp;
    i_host.mem[a + 32'h8] = nx;
  endtask
  task automatic wait_beats(input int n);
    for (int i = 0; i < 2000 && beats < n; i++) @(posedge clk_i);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    {wr_i, rd_i, rx_sof_i} = '0;
    {addr_i, wr_data_i, rx_sof_ch_i} = '0;
    {miscompares, num_checks, beats, nbytes, nobuf_hits} = '0;
    rst_n_i = 1'b0;
    void'($urandom(32'h2880e2be));
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    reg_rd(hdd_pkg::REG_CTRL, v);
    check(v, 32'h0);
    reg_rd(hdd_pkg::REG_GBASE, v);
    check(v, hdd_pkg::GBASE_RST);
    $display("test reset values done");
    // Single end-of-message buffer, then a host-owned polled descriptor
    w0 = $urandom();
    i_host.mem[32'h200] = w0;
    i_host.mem[32'h204] = $urandom();
    i_host.guard_addr = 32'h208;
    put_desc(32'h100, 32'ha000_0008, 32'h200, 32'h140);
    put_desc(32'h140, 32'h0000_0000, 32'h300, 32'h100);
    reg_wr(hdd_pkg::REG_GBASE, 32'h1000);
    reg_wr(hdd_pkg::REG_CTRL, 32'h1);
    reg_wr(8'h40, 32'h103);
    reg_rd(8'h40, v);
    check(v, 32'h100);
    reg_wr(hdd_pkg::REG_ACTIVATE, 32'h1);
    wait_beats(2);
    check(32'(nbytes), 32'd8);
    check(first_data, w0);
    repeat (60) @(posedge clk_i);
    v = i_host.mem[32'h100];
    check(32'(v[31]), 32'(!hdd_pkg::TX_DEV_OWNER));
    check(32'(v[13:0]), 32'd8);
    check(32'(i_host.guard_hits), 32'd0);
    reg_rd(8'h80, v);
    check(v, 32'h140);
    check(i_host.mem[32'h1000], 32'h140);
    $display("test transmit buffer done");
    // Host hands the polled descriptor over late
    i_host.mem[32'h300] = $urandom();
    repeat (40) @(posedge clk_i);
    i_host.mem[32'h140] = 32'ha000_0004;
    wait_beats(3);
    check(32'(beats), 32'd3);
    $display("test polling done");
    // Returning to an already used buffer must not resend it
    reg_wr(8'h40, 32'h100);
    reg_wr(hdd_pkg::REG_ACTIVATE, 32'h1);
    repeat (300) @(posedge clk_i);
    check(32'(beats), 32'd3);
    $display("test no reuse done");
    // Opening flag on a receive list with no device-owned buffer
    put_desc(32'h180, 32'h8000_0040, 32'h400, 32'h180);
    reg_wr(8'h4c, 32'h180);
    reg_wr(hdd_pkg::REG_ACTIVATE, 32'h8);
    repeat (30) @(posedge clk_i);
    rx_sof_ch_i <= 2'd1;
    rx_sof_i <= 1'b1;
    @(posedge clk_i);
    rx_sof_i <= 1'b0;
    repeat (16) @(posedge clk_i);
    check(32'(nobuf_hits), 32'd1);
    check(32'(nobuf_last), 32'd1);
    $display("test no buffer done");
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    finish_test();
  end
endmodule
bind hdd_engine hdd_monitor i_mon (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
  .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
  .mem_req_o(mem_req_o), .mem_o(mem_o), .mem_ack_i(mem_ack_i), .tx_valid_o(tx_valid_o),
  .tx_beat_o(tx_beat_o), .tx_ready_i(tx_ready_i), .rx_req_o(rx_req_o), .rx_sof_i(rx_sof_i),
  .nobuf_event_o(nobuf_event_o));
`default_nettype wire
